// [hdl/nvm_ctrl.sv]
// Program memory protection, data memory access and boot config latches
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
// Overview of operation
// R01: Rows hold 256 bytes plus 32 extra
// R02: Up to 256 individually protected rows
// R03: Four levels; unprotected allows all access
// R04: Only full erase lowers a level
// R05: Field blocks external; full allows internal read
// R06: Factory refuses only external reads
// R07: Data memory read directly, byte granular
// R08: Data writes by command, reads continue
// R09: Data memory is 128 rows of 16
// R10: Data memory bytes start at zero
// R11: Data memory has no correction, no fetch
// R12: Nonvolatile writes last up to 20 ms
// R13: Four config latch bytes applied at reset
// R14: Port drive mode two-bit field per port
// R15: Reset pin enable picks pin function
// R16: Debug enable gates debug access
// R17: Boot clock speed selects 12 or 48
// R18: Debug port select picks debug pins
// R19: Correction enable chooses extra byte use
// R20: Four-bit digital clock phase delay
// R21: Settings sampled once after reset release
// R22: Refused access changes nothing, returns nothing
module nvm_ctrl #(
  parameter int       WRITE_CYC       = nvm_pkg::NV_WRITE_CYC,
  parameter logic     RESET_PIN_DFLT  = 1'b0
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Program memory access
  input  wire logic               pm_req_valid,
  input  wire nvm_pkg::pm_req_t   pm_req,
  output nvm_pkg::pm_rsp_t        pm_rsp,
  // Boot configuration and status
  output nvm_pkg::dev_cfg_t       dev_cfg,
  output logic                    dev_cfg_valid,
  output logic                    nv_busy
);
  typedef enum logic [1:0] {
    PM_IDLE  = 2'b00,
    PM_ERASE = 2'b01
  } pm_state_t;

  localparam int PM_BYTES = nvm_pkg::ROW_BYTES * nvm_pkg::PM_ROWS;
  localparam int PX_BYTES = nvm_pkg::EXTRA_BYTES * nvm_pkg::PM_ROWS;

  // Storage; no reset since contents are nonvolatile
  logic [7:0]  pm_main  [PM_BYTES]         = '{default: 8'h00};
  logic [7:0]  pm_extra [PX_BYTES]         = '{default: 8'h00};
  logic [1:0]  lvl_mem  [nvm_pkg::PM_ROWS] = '{default: nvm_pkg::LVL_UNPROT};
  logic [7:0]  latch    [4]                = '{
    nvm_pkg::LATCH0_RST,
    nvm_pkg::LATCH1_RST,
    nvm_pkg::LATCH2_RST | {RESET_PIN_DFLT, 7'h00},
    nvm_pkg::LATCH3_RST
  };

  pm_state_t        pm_state_r;
  logic [15:0]      erase_addr_r;
  logic [7:0]       lvl_row_r;
  logic [31:0]      stage_r [4];
  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;
  nvm_pkg::pm_rsp_t pm_rsp_r;
  nvm_pkg::dev_cfg_t cfg_r;
  logic             cfg_valid_r;
  logic             busy_r;

  logic             acc;
  logic             wr_ev;
  logic [11:0]      widx;
  logic [31:0]      rd_nxt;
  logic             err_nxt;
  logic [31:0]      dm_rdata;
  logic             dm_busy;
  logic             dm_start;
  logic [7:0]       req_row;
  logic [1:0]       req_lvl;
  logic             req_ok;
  logic [12:0]      req_xaddr;

  // Register map, byte addresses
  // 0x000 port drive modes, ports 0 to 3
  // 0x004 port drive modes, ports 4 to 6 and 12
  // 0x008 reset pin, debug access, port 15 drive mode
  // 0x00c phase delay, correction use, debug port, boot clock
  // 0x010 erase command, bit 0 starts; reads erase running
  // 0x014 row level, write {level, row}; reads the last row named
  // 0x018 status {config loaded, row write busy, erase running}
  // 0x020-0x02c staged data row, byte 0 in the low byte of word 0
  // 0x030 data row command {erase at bit 8, row}; reads busy
  // 0x800-0xfff data memory read window; writes refused
  // Anything else answers with an error

  // APB: one wait cycle, effects at the completing edge
  // Answering a cycle late lets read data come from a flop
  assign acc   = psel && penable && !pready_r;
  assign wr_ev = psel && penable && pready_r && pwrite;
  assign widx  = {2'b00, paddr[11:2]};

  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr[11]) begin
      if (pwrite) begin
        err_nxt = 1'b1; // [R08]
      end else begin
        rd_nxt = dm_rdata; // [R07] [R11]
      end
    end else if (widx <= nvm_pkg::IDX_CLK_DBGP) begin
      rd_nxt = {24'h000000, latch[widx[1:0]]};
    end else if (paddr == nvm_pkg::ADDR_PM_CMD) begin
      rd_nxt = {31'h0, pm_state_r == PM_ERASE};
    end else if (paddr == nvm_pkg::ADDR_PM_LEVEL) begin
      rd_nxt = {22'h0, lvl_mem[lvl_row_r], lvl_row_r};
    end else if (paddr == nvm_pkg::ADDR_STATUS) begin
      rd_nxt = {29'h0, cfg_valid_r, dm_busy, pm_state_r == PM_ERASE};
    end else if (paddr[11:4] == nvm_pkg::ADDR_DM_STAGE[11:4]) begin
      rd_nxt = stage_r[paddr[3:2]];
    end else if (paddr == nvm_pkg::ADDR_DM_CMD) begin
      rd_nxt = {31'h0, dm_busy};
    end else begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= acc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= (acc && !pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= acc && err_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // Latch bytes written by software; take effect only at next reset
  always_ff @(posedge pclk) begin
    if (wr_ev && !paddr[11] && widx <= nvm_pkg::IDX_CLK_DBGP) begin
      latch[widx[1:0]] <= pwdata[7:0]; // [R13]
    end
  end

  // Sample latches once at the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_valid_r <= 1'b0;
      cfg_r       <= '0;
    end else if (!cfg_valid_r) begin
      cfg_valid_r <= 1'b1; // [R21]
      for (int p = 0; p < 4; p++) begin
        cfg_r.port_reset_drive_mode[p] <=
          nvm_pkg::drive_mode_t'(latch[0][2*p +: 2]); // [R14]
        cfg_r.port_reset_drive_mode[p+4] <=
          nvm_pkg::drive_mode_t'(latch[1][2*p +: 2]); // [R14]
      end
      cfg_r.port_reset_drive_mode[8] <=
        nvm_pkg::drive_mode_t'(latch[2][1:0]); // [R14]
      cfg_r.reset_pin_enable <= latch[2][nvm_pkg::RST_PIN_BIT]; // [R15]
      cfg_r.debug_access_enable <= latch[2][nvm_pkg::DBG_EN_BIT]; // [R16]
      cfg_r.boot_clock_speed <= latch[3][nvm_pkg::CLK_SPD_BIT]; // [R17]
      cfg_r.debug_port_select <=
        nvm_pkg::dbg_port_t'(latch[3][nvm_pkg::DPS_LSB +: 2]); // [R18]
      cfg_r.correction_space_enable <= latch[3][nvm_pkg::ECC_BIT]; // [R19]
      cfg_r.digital_clock_phase_delay <=
        latch[3][nvm_pkg::PHS_LSB +: 4]; // [R20]
    end
  end

  assign dev_cfg       = cfg_r;
  assign dev_cfg_valid = cfg_valid_r;

  // Data memory staging and command
  // Stage words survive a command, so one image can go to several rows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        stage_r[i] <= 32'h0000_0000;
      end
    end else if (wr_ev && paddr[11:4] == nvm_pkg::ADDR_DM_STAGE[11:4]) begin
      stage_r[paddr[3:2]] <= pwdata;
    end
  end

  // A command while a row write runs is dropped
  assign dm_start = wr_ev && paddr == nvm_pkg::ADDR_DM_CMD; // [R08]

  // Window read is combinational here; the APB data flop registers it
  data_mem #(
    .WRITE_CYC (WRITE_CYC)
  ) data_mem_i (
    .pclk      (pclk),
    .presetn   (presetn),
    .rd_word   (paddr[10:2]),
    .rd_data   (dm_rdata),
    .cmd_start (dm_start),
    .cmd_row   (pwdata[6:0]),
    .cmd_erase (pwdata[8]),
    .cmd_data  ({stage_r[3], stage_r[2], stage_r[1], stage_r[0]}),
    .busy      (dm_busy)
  );

  // Full program memory erase sequencer
  // One byte per cycle; the program port is refused while it runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_state_r   <= PM_IDLE;
      erase_addr_r <= 16'h0000;
    end else begin
      case (pm_state_r)
        PM_IDLE: begin
          if (wr_ev && paddr == nvm_pkg::ADDR_PM_CMD && pwdata[0]) begin
            pm_state_r   <= PM_ERASE;
            erase_addr_r <= 16'h0000;
          end
        end
        PM_ERASE: begin
          erase_addr_r <= erase_addr_r + 16'h0001;
          if (erase_addr_r == 16'hffff) begin
            pm_state_r <= PM_IDLE;
          end
        end
        default: pm_state_r <= PM_IDLE;
      endcase
    end
  end

  // Levels: set only on an unprotected row, cleared only by erase
  always_ff @(posedge pclk) begin
    if (pm_state_r == PM_ERASE) begin
      // A row unlocks only after its last byte; a cut erase leaves the rest locked
      if (erase_addr_r[7:0] == 8'hff) begin
        lvl_mem[erase_addr_r[15:8]] <= nvm_pkg::LVL_UNPROT; // [R04]
      end
    end else if (wr_ev && paddr == nvm_pkg::ADDR_PM_LEVEL) begin
      if (lvl_mem[pwdata[7:0]] == nvm_pkg::LVL_UNPROT) begin
        lvl_mem[pwdata[7:0]] <= pwdata[9:8]; // [R02] [R04]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_row_r <= 8'h00;
    end else if (wr_ev && paddr == nvm_pkg::ADDR_PM_LEVEL) begin
      lvl_row_r <= pwdata[7:0];
    end
  end

  // Access check against the row level
  // Extra bytes follow the level of their row
  assign req_row   = pm_req.addr[15:8];
  assign req_lvl   = lvl_mem[req_row];
  assign req_xaddr = {req_row, pm_req.addr[4:0]}; // [R01]

  always_comb begin
    req_ok = 1'b0;
    if (pm_req.write) begin
      if (pm_req.external) begin
        req_ok = req_lvl == nvm_pkg::LVL_UNPROT ||
                 req_lvl == nvm_pkg::LVL_FACTORY; // [R05] [R06]
      end else begin
        req_ok = req_lvl != nvm_pkg::LVL_FULL; // [R05]
      end
    end else begin
      // Internal reads pass at every level [R03]
      req_ok = !pm_req.external || req_lvl == nvm_pkg::LVL_UNPROT; // [R06]
    end
  end

  always_ff @(posedge pclk) begin
    if (pm_state_r == PM_ERASE) begin
      pm_main[erase_addr_r] <= 8'h00;
      if (erase_addr_r[15:13] == 3'b000) begin
        pm_extra[erase_addr_r[12:0]] <= 8'h00;
      end
    end else if (pm_req_valid && pm_req.write && req_ok) begin // [R22]
      if (pm_req.extra) begin
        pm_extra[req_xaddr] <= pm_req.wdata;
      end else begin
        pm_main[pm_req.addr] <= pm_req.wdata;
      end
    end
  end

  // One-cycle answer; refused or erasing gives denied with zero data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_rsp_r <= '0;
    end else begin
      pm_rsp_r.valid  <= pm_req_valid;
      pm_rsp_r.denied <= pm_req_valid && (!req_ok || pm_state_r == PM_ERASE);
      if (pm_req_valid && req_ok && pm_state_r == PM_IDLE && !pm_req.write) begin
        pm_rsp_r.rdata <= pm_req.extra ? pm_extra[req_xaddr]
                                       : pm_main[pm_req.addr];
      end else begin
        pm_rsp_r.rdata <= 8'h00; // [R22]
      end
    end
  end

  assign pm_rsp = pm_rsp_r;

  // Registered so the status pin comes from a flop; it lags one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= dm_busy || pm_state_r == PM_ERASE; // [R12]
    end
  end

  assign nv_busy = busy_r;
endmodule

// [hdl/nvm_pkg.sv]
// Shared constants and carriers for the nonvolatile control block
package nvm_pkg;
  // Register indexes, byte address four times the index; the ADDR constants are byte addresses
  localparam logic [11:0] IDX_DRIVE_LOW  = 12'h000;
  localparam logic [11:0] IDX_DRIVE_HIGH = 12'h001;
  localparam logic [11:0] IDX_RST_DBG    = 12'h002;
  localparam logic [11:0] IDX_CLK_DBGP   = 12'h003;
  localparam logic [11:0] ADDR_PM_CMD    = 12'h010;
  localparam logic [11:0] ADDR_PM_LEVEL  = 12'h014;
  localparam logic [11:0] ADDR_STATUS    = 12'h018;
  localparam logic [11:0] ADDR_DM_STAGE  = 12'h020;
  localparam logic [11:0] ADDR_DM_CMD    = 12'h030;
  localparam logic [11:0] ADDR_DM_WIN    = 12'h800;
  // Factory latch contents
  localparam logic [7:0] LATCH0_RST = 8'h00;
  localparam logic [7:0] LATCH1_RST = 8'h00;
  localparam logic [7:0] LATCH2_RST = 8'h40;
  localparam logic [7:0] LATCH3_RST = 8'h0a;
  // Latch field positions
  localparam int RST_PIN_BIT  = 7;
  localparam int DBG_EN_BIT   = 6;
  localparam int CLK_SPD_BIT  = 0;
  localparam int DPS_LSB      = 1;
  localparam int ECC_BIT      = 3;
  localparam int PHS_LSB      = 4;
  // Memory geometry
  localparam int ROW_BYTES    = 256;
  localparam int EXTRA_BYTES  = 32;
  localparam int PM_ROWS      = 256;
  localparam int DM_ROWS      = 128;
  localparam int DM_ROW_BYTES = 16;
  // Write time
  localparam int NV_WRITE_MS  = 20;
  localparam int CLK_KHZ      = 100000;
  localparam int NV_WRITE_CYC = NV_WRITE_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    LVL_UNPROT  = 2'b00,
    LVL_FACTORY = 2'b01,
    LVL_FIELD   = 2'b10,
    LVL_FULL    = 2'b11
  } prot_level_t;

  typedef enum logic [1:0] {
    DRV_ANALOG_HIZ  = 2'b00,
    DRV_DIGITAL_HIZ = 2'b01,
    DRV_PULL_UP     = 2'b10,
    DRV_PULL_DOWN   = 2'b11
  } drive_mode_t;

  typedef enum logic [1:0] {
    DBGP_JTAG5 = 2'b00,
    DBGP_JTAG4 = 2'b01,
    DBGP_SWD   = 2'b10,
    DBGP_OFF   = 2'b11
  } dbg_port_t;

  typedef struct packed {
    logic        external;
    logic        write;
    logic        extra;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pm_req_t;

  typedef struct packed {
    logic       valid;
    logic       denied;
    logic [7:0] rdata;
  } pm_rsp_t;

  // Drive modes for ports 0-6, 12 and 15, in that order
  typedef struct packed {
    drive_mode_t [8:0] port_reset_drive_mode;
    logic              reset_pin_enable;
    logic              debug_access_enable;
    logic              boot_clock_speed;
    dbg_port_t         debug_port_select;
    logic              correction_space_enable;
    logic [3:0]        digital_clock_phase_delay;
  } dev_cfg_t;
endpackage

// [hdl/data_mem.sv]
// Row-programmed byte data memory with timed write
`timescale 1ns/1ps
module data_mem #(
  parameter int WRITE_CYC = nvm_pkg::NV_WRITE_CYC
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Word read port
  input  wire logic [8:0]   rd_word,
  output logic      [31:0]  rd_data,
  // Row command
  input  wire logic         cmd_start,
  input  wire logic [6:0]   cmd_row,
  input  wire logic         cmd_erase,
  input  wire logic [127:0] cmd_data,
  output logic              busy
);
  localparam int NB = nvm_pkg::DM_ROWS * nvm_pkg::DM_ROW_BYTES;

  logic [7:0]   mem [NB] = '{default: 8'h00}; // [R10]
  logic [31:0]  cnt_r;
  logic [6:0]   row_r;
  logic [127:0] data_r;
  logic         busy_r;

  // Reads stay open during a row write [R07] [R08]
  assign rd_data = {mem[{rd_word, 2'd3}], mem[{rd_word, 2'd2}],
                    mem[{rd_word, 2'd1}], mem[{rd_word, 2'd0}]};
  assign busy = busy_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      cnt_r  <= 32'h0000_0000;
      row_r  <= 7'h00;
      data_r <= 128'h0;
    end else if (!busy_r && cmd_start) begin
      busy_r <= 1'b1;
      cnt_r  <= 32'h0000_0000;
      row_r  <= cmd_row;
      data_r <= cmd_erase ? 128'h0 : cmd_data;
    end else if (busy_r) begin
      if (cnt_r == 32'(WRITE_CYC - 1)) begin
        busy_r <= 1'b0; // [R12]
      end
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  // Whole row lands at the end of the write time [R09]
  always_ff @(posedge pclk) begin
    if (busy_r && cnt_r == 32'(WRITE_CYC - 1)) begin
      for (int b = 0; b < nvm_pkg::DM_ROW_BYTES; b++) begin
        mem[{row_r, 4'(b)}] <= data_r[8*b +: 8];
      end
    end
  end
endmodule

// [bench/nvm_ctrl_sva.sv]
// Port assertions for the nonvolatile control block
`timescale 1ns/1ps
module nvm_ctrl_sva (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Program memory and boot config
  input wire logic              pm_req_valid,
  input wire nvm_pkg::pm_rsp_t  pm_rsp,
  input wire nvm_pkg::dev_cfg_t dev_cfg,
  input wire logic              dev_cfg_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_take;
    psel && penable && !pready;
  endsequence
  sequence apb_pulse;
    pready ##1 !pready;
  endsequence
  wait_state_a: assert property (apb_take |=> apb_pulse)
    else $error("apb answer not one cycle after access");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without an access");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  window_write_a: assert property (psel && penable && !pready && pwrite && paddr[11]
    |=> pready && pslverr)
    else $error("data window write not refused");
  err_pulse_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  pm_answer_a: assert property (pm_req_valid |=> pm_rsp.valid)
    else $error("program memory request not answered");
  pm_cause_a: assert property (pm_rsp.valid |-> $past(pm_req_valid))
    else $error("program memory answer without request");
  denied_data_a: assert property (pm_rsp.valid && pm_rsp.denied |-> pm_rsp.rdata == 8'h00)
    else $error("refused access returned data");
  cfg_load_a: assert property (presetn && !dev_cfg_valid |=> dev_cfg_valid)
    else $error("boot config not loaded after reset");
  cfg_hold_a: assert property (dev_cfg_valid |=> dev_cfg_valid && $stable(dev_cfg))
    else $error("boot config changed between resets");
endmodule

bind nvm_ctrl nvm_ctrl_sva nvm_ctrl_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pm_req_valid(pm_req_valid), .pm_rsp(pm_rsp), .dev_cfg(dev_cfg),
  .dev_cfg_valid(dev_cfg_valid));

// [bench/nvm_access_model.sv]
// Processor and debug tool side of the program memory port
`timescale 1ns/1ps
module nvm_access_model (
  // Clock
  input  wire logic             pclk,
  // Program memory port
  output logic                  pm_req_valid,
  output nvm_pkg::pm_req_t      pm_req,
  input  wire nvm_pkg::pm_rsp_t pm_rsp
);
  initial begin
    pm_req_valid = 1'b0;
    pm_req = '0;
  end
  // One byte request; may run while a data row write is in progress
  task automatic access(input logic ext, input logic wr, input logic [15:0] addr,
                        input logic [7:0] wdata, output nvm_pkg::pm_rsp_t rsp);
    @(posedge pclk);
    pm_req_valid <= 1'b1;
    pm_req <= '{external: ext, write: wr, extra: 1'b0, addr: addr, wdata: wdata};
    @(posedge pclk);
    pm_req_valid <= 1'b0;
    // Released lines must not look like the last request
    pm_req <= ~pm_req;
    @(posedge pclk);
    rsp = pm_rsp;
  endtask
endmodule

// [bench/nvm_ctrl_tb.sv]
// Self-checking testbench for the nonvolatile control block
`timescale 1ns/1ps
module nvm_ctrl_tb;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              pm_req_valid;
  nvm_pkg::pm_req_t  pm_req;
  nvm_pkg::pm_rsp_t  pm_rsp;
  nvm_pkg::dev_cfg_t dev_cfg;
  logic              dev_cfg_valid;
  logic              nv_busy;
  int                err_total = 0;
  int                comparisons = 0;
  logic [31:0]       q;
  logic              e;
  nvm_pkg::pm_rsp_t  r;
  nvm_pkg::dev_cfg_t exp_cfg;
  logic [31:0]       lat;
  logic [15:0]       pa;

  always #5 pclk = ~pclk;

  nvm_ctrl #(.WRITE_CYC(20)) nvm_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pm_req_valid(pm_req_valid), .pm_req(pm_req),
    .pm_rsp(pm_rsp), .dev_cfg(dev_cfg), .dev_cfg_valid(dev_cfg_valid), .nv_busy(nv_busy));
  nvm_access_model nvm_access_model_i (.pclk(pclk), .pm_req_valid(pm_req_valid),
    .pm_req(pm_req), .pm_rsp(pm_rsp));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write answers always carry zero data, but only valid and denied are compared
  task automatic chk_rsp(input nvm_pkg::pm_rsp_t g, input logic den, input logic [7:0] d,
                         input logic rd);
    chk({22'h0, g.valid, g.denied, rd ? g.rdata : 8'h00}, {22'h0, 1'b1, den, rd ? d : 8'h00});
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  function automatic nvm_pkg::dev_cfg_t cfg_of(input logic [31:0] l);
    nvm_pkg::dev_cfg_t c;
    for (int p = 0; p < 9; p++)
      c.port_reset_drive_mode[p] = nvm_pkg::drive_mode_t'(l[2*p +: 2]);
    c.reset_pin_enable          = l[23];
    c.debug_access_enable       = l[22];
    c.boot_clock_speed          = l[24];
    c.debug_port_select         = nvm_pkg::dbg_port_t'(l[26:25]);
    c.correction_space_enable   = l[27];
    c.digital_clock_phase_delay = l[31:28];
    return c;
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    end_of_test();
  end

  initial begin
    do_reset();
    lat = 32'h0a40_0000;
    exp_cfg = cfg_of(lat);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(q, {24'h0, lat[8*i +: 8]});
    end
    chk(32'({dev_cfg_valid, dev_cfg}), 32'({1'b1, exp_cfg}));
    $display("test factory done");
    // Every debug port code, both values of each single-bit option
    for (int k = 0; k < 4; k++) begin
      lat = {4'(k + 5), k[0], 2'(k), ~k[0], k[0], ~k[0], 4'h0, 2'(k), 8'h1b, 8'he4};
      for (int i = 0; i < 4; i++) apb(1'b1, 12'(4 * i), {24'h0, lat[8*i +: 8]});
      for (int i = 0; i < 4; i++) begin
        apb(1'b0, 12'(4 * i), 32'h0);
        chk(q, {24'h0, lat[8*i +: 8]});
      end
      chk(32'({dev_cfg_valid, dev_cfg}), 32'({1'b1, exp_cfg}));
      do_reset();
      exp_cfg = cfg_of(lat);
      chk(32'({dev_cfg_valid, dev_cfg}), 32'({1'b1, exp_cfg}));
    end
    $display("test latches done");
    apb(1'b0, 12'h040, 32'h0);
    chk({e, q[30:0]}, 32'h8000_0000);
    apb(1'b1, nvm_pkg::ADDR_DM_WIN, 32'hffff_ffff);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'hff0, 32'h0);
    chk(q, 32'h0);
    $display("test refusals done");
    for (int n = 0; n < 4; n++) begin
      pa = {8'(n * 85), 8'h04};
      nvm_access_model_i.access(1'b0, 1'b1, pa, 8'h5a, r);
      apb(1'b1, nvm_pkg::ADDR_PM_LEVEL, {22'h0, 2'(n), pa[15:8]});
    end
    apb(1'b1, nvm_pkg::ADDR_PM_LEVEL, 32'h0000_00ff);
    apb(1'b0, nvm_pkg::ADDR_PM_LEVEL, 32'h0);
    chk(q, 32'h0000_03ff);
    for (int n = 0; n < 4; n++) begin
      pa = {8'(n * 85), 8'h04};
      nvm_access_model_i.access(1'b1, 1'b0, pa, 8'h00, r);
      chk_rsp(r, n != 0, (n == 0) ? 8'h5a : 8'h00, 1'b1);
      nvm_access_model_i.access(1'b1, 1'b1, pa, 8'ha5, r);
      chk_rsp(r, n > 1, 8'h00, 1'b0);
      nvm_access_model_i.access(1'b0, 1'b1, pa, 8'h3c, r);
      chk_rsp(r, n == 3, 8'h00, 1'b0);
      nvm_access_model_i.access(1'b0, 1'b0, pa, 8'h00, r);
      chk_rsp(r, 1'b0, (n == 3) ? 8'h5a : 8'h3c, 1'b1);
    end
    $display("test protection done");
    for (int i = 0; i < 4; i++)
      apb(1'b1, 12'(nvm_pkg::ADDR_DM_STAGE + 4 * i), 32'h0302_0100 + 32'h0404_0404 * i);
    apb(1'b1, nvm_pkg::ADDR_DM_CMD, 32'h0000_007f);
    nvm_access_model_i.access(1'b0, 1'b0, 16'h0004, 8'h00, r);
    chk_rsp(r, 1'b0, 8'h3c, 1'b1);
    chk({31'h0, nv_busy}, 32'h1);
    q = 32'h2;
    while (q[1] !== 1'b0) apb(1'b0, nvm_pkg::ADDR_STATUS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(12'hff0 + 4 * i), 32'h0);
      chk(q, 32'h0302_0100 + 32'h0404_0404 * i);
    end
    apb(1'b0, 12'hfe0, 32'h0);
    chk(q, 32'h0);
    $display("test data memory done");
    apb(1'b1, nvm_pkg::ADDR_PM_CMD, 32'h1);
    nvm_access_model_i.access(1'b0, 1'b0, 16'h0004, 8'h00, r);
    chk_rsp(r, 1'b1, 8'h00, 1'b1);
    q = 32'h1;
    while (q[0] !== 1'b0) apb(1'b0, nvm_pkg::ADDR_PM_CMD, 32'h0);
    apb(1'b1, nvm_pkg::ADDR_PM_LEVEL, 32'h0000_00ff);
    apb(1'b0, nvm_pkg::ADDR_PM_LEVEL, 32'h0);
    chk(q, 32'h0000_00ff);
    nvm_access_model_i.access(1'b1, 1'b0, 16'hff04, 8'h00, r);
    chk_rsp(r, 1'b0, 8'h00, 1'b1);
    $display("test erase done");
    end_of_test();
  end
endmodule
